// file: src/lcf_pkg.sv
/*
 lock current fault handler package: register map, field layout, timing tables, types.
 assumes a 10 MHz clock and a phase current magnitude with an LSB of 1/64 A.
*/
package lcf_pkg;
  // =====================================================================
  // register map (byte addresses)
  localparam logic [7:0] LCF_FAULT_SETTINGS_ONE_ADDR = 8'h90;
  localparam logic [7:0] LCF_LOCK_CONTROL_ADDR = 8'h94;
  localparam logic [7:0] LCF_LOCK_STATUS_ADDR = 8'h98;
  localparam logic [7:0] LCF_IRQ_STATUS_ADDR = 8'h9c;
  localparam logic [7:0] LCF_IRQ_MASK_ADDR = 8'ha0;
  localparam logic [31:0] LCF_FAULT_SETTINGS_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] LCF_FAULT_SETTINGS_ONE_WMASK = 32'h7fff_ffff;
  // =====================================================================
  // field positions
  localparam int LCF_THRESH_LSB = 19;
  localparam int LCF_MODE_LSB = 15;
  localparam int LCF_FILTER_LSB = 11;
  localparam int LCF_RETRY_WAIT_LSB = 7;
  localparam int LCF_CLEAR_BIT = 8;
  localparam logic [3:0] LCF_RETRY_LIMIT_RST = 4'h0;
  localparam logic [2:0] LCF_IRQ_MASK_RST = 3'h0;
  // =====================================================================
  // timing: one tick is 0.05 ms
  localparam int LCF_CLK_PERIOD_NS = 100;
  localparam int LCF_TICK_NS = 50000;
  localparam int LCF_TICK_CYCLES = LCF_TICK_NS / LCF_CLK_PERIOD_NS;
  // filter time in ticks: 0.05,0.1,0.2,0.5,1,2.5,5,7.5,10,25,50,75,100,200,500,1000 ms
  localparam logic [17:0] LCF_FILTER_TICKS [16] = '{
    18'd1, 18'd2, 18'd4, 18'd10, 18'd20, 18'd50, 18'd100, 18'd150,
    18'd200, 18'd500, 18'd1000, 18'd1500, 18'd2000, 18'd4000, 18'd10000, 18'd20000};
  // retry wait in ticks: 300 ms, 500 ms, 1 s, 2 s .. 8 s
  localparam logic [17:0] LCF_RETRY_TICKS [10] = '{
    18'd6000, 18'd10000, 18'd20000, 18'd40000, 18'd60000,
    18'd80000, 18'd100000, 18'd120000, 18'd140000, 18'd160000};
  // threshold in 1/64 A: 0.078125 A .. 5.0 A
  localparam logic [8:0] LCF_THRESH_LSBS [16] = '{
    9'd5, 9'd10, 9'd20, 9'd40, 9'd60, 9'd80, 9'd100, 9'd120,
    9'd140, 9'd160, 9'd180, 9'd200, 9'd220, 9'd240, 9'd280, 9'd320};
  // =====================================================================
  // types
  typedef enum logic [1:0] {LCF_ACT_HIZ, LCF_ACT_HS, LCF_ACT_LS, LCF_ACT_NONE} lcf_action_t;
  typedef enum logic [1:0] {LCF_CLS_LATCH, LCF_CLS_RETRY, LCF_CLS_REPORT, LCF_CLS_OFF} lcf_class_t;
  typedef struct packed {
    logic hiz;
    logic hs_brake;
    logic ls_brake;
  } lcf_bridge_t;
  typedef struct packed {
    logic latched;
    logic auto_cleared;
    logic detected;
  } lcf_irq_t;
endpackage

// file: src/lcf_lock_current_fault.sv
/*
 lock current fault handler: apb register slave, overcurrent filter, mode driven
 fault / retry / brake control, sticky interrupt status.
 assumes current samples synchronous to MCLK_IN; bridge and fault pin consumers outside.
*/
// Contract
// - mode field is 4 bits at 18..15, read/write, reset zero.
// - modes 0h/1h latch fault, assert fault pin, tristate bridge.
// - mode 2h latches fault, asserts fault pin, applies high-side brake.
// - mode 3h latches fault, asserts fault pin, applies low-side brake.
// - modes 4h/5h tristate, fault pin, auto clear after wait, latch past limit.
// - mode 6h high-side brake, fault pin, auto clear up to retry limit.
// - mode 7h low-side brake, auto clear; past limit latch with low-side brake.
// - mode 8h only reports on fault pin; bridge drive unchanged.
// - modes 9h to Fh disable detection: no fault, no action.
// - overcurrent flagged only after persisting for filter time selected at bits 14..11.
// - adc current compared against 4-bit threshold code, 0.078125 A to 5.0 A.
// - wait the selected retry time before each automatic clear.
module lcf_lock_current_fault import lcf_pkg::*; #(
  parameter int CUR_W = 12,
  parameter int TICK_CYCLES = LCF_TICK_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [CUR_W-1:0] CURRENT_IN,
  output logic FAULT_OUT_N_OUT,
  output lcf_bridge_t BRIDGE_OUT,
  output logic IRQ_OUT
);

  // =====================================================================
  // decoding helpers
  function automatic lcf_class_t class_of(input logic [3:0] m);
    case (m)
      4'h0, 4'h1, 4'h2, 4'h3: class_of = LCF_CLS_LATCH;
      4'h4, 4'h5, 4'h6, 4'h7: class_of = LCF_CLS_RETRY;
      4'h8: class_of = LCF_CLS_REPORT;
      default: class_of = LCF_CLS_OFF;
    endcase
  endfunction

  function automatic lcf_action_t action_of(input logic [3:0] m);
    case (m)
      4'h2, 4'h6: action_of = LCF_ACT_HS;
      4'h3, 4'h7: action_of = LCF_ACT_LS;
      4'h0, 4'h1, 4'h4, 4'h5: action_of = LCF_ACT_HIZ;
      default: action_of = LCF_ACT_NONE;
    endcase
  endfunction

  // one decoder for the map; anything else answers with an error
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      LCF_FAULT_SETTINGS_ONE_ADDR, LCF_LOCK_CONTROL_ADDR, LCF_LOCK_STATUS_ADDR,
      LCF_IRQ_STATUS_ADDR, LCF_IRQ_MASK_ADDR: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  typedef enum logic [1:0] {ST_WATCH, ST_RETRY, ST_LATCHED, ST_REPORT} lcf_state_t;

  logic [31:0] cfg_q;
  logic [3:0] retry_limit_q;
  lcf_irq_t irq_status_q;
  lcf_irq_t irq_mask_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic fault_n_q;
  lcf_bridge_t bridge_q;
  logic irq_q;
  lcf_state_t state_q;
  logic [17:0] tmr_q;
  logic [3:0] retry_cnt_q;
  logic [$clog2(TICK_CYCLES+1)-1:0] div_q;
  logic tick_q;
  lcf_action_t act_q;

  logic [3:0] mode;
  logic [3:0] filt_code;
  logic [3:0] wait_code;
  logic over;
  logic [17:0] filt_ticks;
  logic [17:0] wait_ticks;
  logic acc;
  logic wr;
  logic mapped;
  logic clr_fault;
  logic detect;
  logic filt_done;
  logic wait_done;
  logic faulted;
  lcf_class_t mode_class;
  lcf_irq_t irq_set;

  assign mode = cfg_q[LCF_MODE_LSB +: 4];
  assign mode_class = class_of(mode);
  assign filt_code = cfg_q[LCF_FILTER_LSB +: 4];
  assign wait_code = cfg_q[LCF_RETRY_WAIT_LSB +: 4];
  assign filt_ticks = LCF_FILTER_TICKS[filt_code];
  // codes past 9h have no defined time; they hold the longest wait
  assign wait_ticks = (wait_code > 4'h9) ? LCF_RETRY_TICKS[9] : LCF_RETRY_TICKS[wait_code];
  assign over = CURRENT_IN > CUR_W'(LCF_THRESH_LSBS[cfg_q[LCF_THRESH_LSB +: 4]]);

  // =====================================================================
  // apb slave: one wait state, access completes when pready_q is high
  assign acc = PSEL_IN & PENABLE_IN & pready_q;
  assign wr = acc & PWRITE_IN;
  assign mapped = addr_known(PADDR_IN);
  assign clr_fault = wr && (PADDR_IN == LCF_LOCK_CONTROL_ADDR) && PWDATA_IN[LCF_CLEAR_BIT];

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= PSEL_IN & PENABLE_IN & ~pready_q;
      pslverr_q <= PSEL_IN & PENABLE_IN & ~pready_q & ~mapped;
      if (PSEL_IN && PENABLE_IN && !pready_q && !PWRITE_IN) begin
        case (PADDR_IN)
          LCF_FAULT_SETTINGS_ONE_ADDR: prdata_q <= cfg_q;
          LCF_LOCK_CONTROL_ADDR: prdata_q <= {28'h000_0000, retry_limit_q};
          LCF_LOCK_STATUS_ADDR: prdata_q <= {23'h00_0000, over, retry_cnt_q, 2'h0, state_q};
          LCF_IRQ_STATUS_ADDR: prdata_q <= {29'h0000_0000, irq_status_q};
          LCF_IRQ_MASK_ADDR: prdata_q <= {29'h0000_0000, irq_mask_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfg_q <= LCF_FAULT_SETTINGS_ONE_RST;
      retry_limit_q <= LCF_RETRY_LIMIT_RST;
      irq_mask_q <= LCF_IRQ_MASK_RST;
    end else if (wr) begin
      case (PADDR_IN)
        LCF_FAULT_SETTINGS_ONE_ADDR: cfg_q <= PWDATA_IN & LCF_FAULT_SETTINGS_ONE_WMASK;
        LCF_LOCK_CONTROL_ADDR: retry_limit_q <= PWDATA_IN[3:0];
        LCF_IRQ_MASK_ADDR: irq_mask_q <= PWDATA_IN[2:0];
        default: ;
      endcase
    end
  end

  // =====================================================================
  // interrupts: sticky, write one to clear, a new event wins over the clear
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_status_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      if (wr && PADDR_IN == LCF_IRQ_STATUS_ADDR) begin
        irq_status_q <= (irq_status_q & ~lcf_irq_t'(PWDATA_IN[2:0])) | irq_set;
      end else begin
        irq_status_q <= irq_status_q | irq_set;
      end
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // =====================================================================
  // 0.05 ms tick divider
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == $bits(div_q)'(TICK_CYCLES - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // =====================================================================
  // fault state machine; the timer serves the filter while watching and the wait while retrying
  // condition must hold on every clock of the filter window; a gap restarts it
  // one tick past the table value: the first tick may come at once, so the filter never undercuts its time
  assign filt_done = (tmr_q >= filt_ticks);
  assign wait_done = (tmr_q + 18'd1 >= wait_ticks);
  assign detect = (state_q == ST_WATCH) && over && tick_q && filt_done && (mode_class != LCF_CLS_OFF);

  always_comb begin
    irq_set = 3'h0;
    irq_set.detected = detect;
    irq_set.auto_cleared = (state_q == ST_RETRY) && tick_q && wait_done;
    irq_set.latched = detect && ((mode_class == LCF_CLS_LATCH) ||
                      ((mode_class == LCF_CLS_RETRY) && (retry_cnt_q >= retry_limit_q)));
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_WATCH;
      tmr_q <= 18'd0;
      retry_cnt_q <= 4'h0;
      act_q <= LCF_ACT_NONE;
    end else if (mode_class == LCF_CLS_OFF) begin
      // disabling drops any fault in progress
      state_q <= ST_WATCH;
      tmr_q <= 18'd0;
      retry_cnt_q <= 4'h0;
      act_q <= LCF_ACT_NONE;
    end else begin
      case (state_q)
        ST_WATCH: begin
          if (!over) begin
            tmr_q <= 18'd0;
          end else if (detect) begin
            tmr_q <= 18'd0;
            act_q <= action_of(mode);
            case (mode_class)
              LCF_CLS_LATCH: state_q <= ST_LATCHED;
              LCF_CLS_RETRY: begin
                // limit reached: this fault stays latched with the mode's bridge action
                if (retry_cnt_q >= retry_limit_q) begin
                  state_q <= ST_LATCHED;
                end else begin
                  state_q <= ST_RETRY;
                end
              end
              default: state_q <= ST_REPORT;
            endcase
          end else if (tick_q) begin
            tmr_q <= tmr_q + 18'd1;
          end
        end
        ST_RETRY: begin
          if (clr_fault) begin
            state_q <= ST_WATCH;
            tmr_q <= 18'd0;
            retry_cnt_q <= 4'h0;
            act_q <= LCF_ACT_NONE;
          end else if (irq_set.auto_cleared) begin
            state_q <= ST_WATCH;
            tmr_q <= 18'd0;
            retry_cnt_q <= retry_cnt_q + 4'h1;
            act_q <= LCF_ACT_NONE;
          end else if (tick_q) begin
            tmr_q <= tmr_q + 18'd1;
          end
        end
        ST_LATCHED: begin
          if (clr_fault) begin
            state_q <= ST_WATCH;
            tmr_q <= 18'd0;
            retry_cnt_q <= 4'h0;
            act_q <= LCF_ACT_NONE;
          end
        end
        ST_REPORT: begin
          // report-only follows the current: released once it falls below threshold
          if (!over) begin
            state_q <= ST_WATCH;
          end
        end
        default: state_q <= ST_WATCH;
      endcase
    end
  end

  // =====================================================================
  // registered outputs
  // bridge flops follow the action captured at detect, not the live mode field
  assign faulted = (state_q != ST_WATCH);

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fault_n_q <= 1'b1;
      bridge_q <= 3'h0;
    end else begin
      fault_n_q <= !faulted;
      bridge_q.hiz <= faulted && (act_q == LCF_ACT_HIZ);
      bridge_q.hs_brake <= faulted && (act_q == LCF_ACT_HS);
      bridge_q.ls_brake <= faulted && (act_q == LCF_ACT_LS);
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign FAULT_OUT_N_OUT = fault_n_q;
  assign BRIDGE_OUT = bridge_q;
  assign IRQ_OUT = irq_q;

endmodule

// file: dv/lcf_lock_current_fault_assertions.sv
/*
 checker for the lock current fault handler: apb timing, fault pin, bridge action.
 assumes it is bound to the top module and sees only its ports.
*/
module lcf_lock_current_fault_checker import lcf_pkg::*; #(
  parameter int CUR_W = 12,
  parameter int TICK_CYCLES = LCF_TICK_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PSLVERR_OUT,
  input wire logic PREADY_OUT,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic [CUR_W-1:0] CURRENT_IN,
  input wire logic FAULT_OUT_N_OUT,
  input lcf_bridge_t BRIDGE_OUT,
  input wire logic IRQ_OUT
);
  // =====================================================================
  // properties
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready held");
  ready_wait_a: assert property ($rose(PENABLE_IN) && PSEL_IN |=> PREADY_OUT) else $error("ready late");
  err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
  rdata_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0) else $error("read data idle");
  bridge_excl_a: assert property ($onehot0(BRIDGE_OUT)) else $error("two actions");
  action_fault_a: assert property (BRIDGE_OUT != 3'h0 |-> !FAULT_OUT_N_OUT) else $error("action no fault");
  // smallest threshold is 5 lsb, compare is strict
  // the detect edge lies two clocks before the pin falls
  fault_cause_a: assert property ($fell(FAULT_OUT_N_OUT) |->
    $past(CURRENT_IN, 2) > 5) else $error("fault without current");
  reset_quiet_a: assert property (!$past(RST_N_IN) |-> FAULT_OUT_N_OUT && BRIDGE_OUT == 3'h0 && !IRQ_OUT)
    else $error("outputs after reset");
  // irq rises with a fault, just after an auto clear, or after a write unmasks a stale bit
  irq_cause_a: assert property ($rose(IRQ_OUT) |->
    !FAULT_OUT_N_OUT || !$past(FAULT_OUT_N_OUT) || $past(PSEL_IN, 2)) else $error("irq without cause");
  cover property (PSLVERR_OUT);
  cover property (BRIDGE_OUT.hs_brake);
  cover property (IRQ_OUT && BRIDGE_OUT.ls_brake);
endmodule

bind lcf_lock_current_fault lcf_lock_current_fault_checker #(.CUR_W(CUR_W), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PSLVERR_OUT(PSLVERR_OUT), .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT), .CURRENT_IN(CURRENT_IN),
  .FAULT_OUT_N_OUT(FAULT_OUT_N_OUT), .BRIDGE_OUT(BRIDGE_OUT), .IRQ_OUT(IRQ_OUT));

// file: dv/lcf_motor_model.sv
/*
 far side: gate driver and current sense adc, behavioural.
 assumes the bench sets the demanded phase current.
*/
module lcf_motor_model import lcf_pkg::*; (
  input wire logic clk_in,
  input lcf_bridge_t bridge_in,
  input wire logic [11:0] demand_in,
  output logic [11:0] current_out = 12'h000
);
  // =====================================================================
  // adc sample, one cycle behind; a tristated bridge carries no current
  always_ff @(posedge clk_in) begin
    current_out <= bridge_in.hiz ? 12'h000 : demand_in;
  end
endmodule

// file: dv/tb_lock_current_fault_handler.sv
/*
 testbench for the lock current fault handler: registers, modes, filter, retries.
 assumes TICK_CYCLES of 2, so one 0.05 ms tick is two clocks.
*/
module tb_lock_current_fault_handler import lcf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, err, fault_n, irq;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd, wv;
  logic [11:0] cur, demand = 12'h000;
  lcf_bridge_t br;
  int n_mismatch = 0, checks = 0, seed = 99, t;
  int thr[16] = '{5, 10, 20, 40, 60, 80, 100, 120, 140, 160, 180, 200, 220, 240, 280, 320};
  int rq[$] = '{4, 6, 7};
  logic [7:0] ra[4] = '{8'h90, 8'h94, 8'ha0, 8'h04};
  initial forever #50 clk = ~clk;
  lcf_lock_current_fault #(.CUR_W(12), .TICK_CYCLES(2)) u_dut (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .CURRENT_IN(cur), .FAULT_OUT_N_OUT(fault_n), .BRIDGE_OUT(br), .IRQ_OUT(irq));
  lcf_motor_model u_motor (.clk_in(clk), .bridge_in(br), .demand_in(demand), .current_out(cur));
  // =====================================================================
  // tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no cycle limit here: the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic logic [2:0] exp_br(int m);
    if (m inside {0, 1, 4, 5}) return 3'h4;
    if (m inside {2, 6}) return 3'h2;
    if (m inside {3, 7}) return 3'h1;
    return 3'h0;
  endfunction
  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // =====================================================================
  // sequence
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, 32'h0);
      chk(err, i == 3);
    end
    wv = $random(seed) | 32'h8000_0000;
    apb(1'b1, 8'h90, wv);
    apb(1'b0, 8'h90, 32'h0);
    chk(rd, wv & 32'h7fff_ffff);
    for (int m = 0; m < 16; m++) begin
      t = $unsigned($random(seed)) % 16;
      apb(1'b1, 8'ha0, 32'(m % 2 * 7));
      apb(1'b1, 8'h90, 32'(t << 19 | m << 15));
      demand <= 12'(thr[t]);
      repeat (20) @(posedge clk);
      chk(fault_n, 1);
      demand <= 12'(thr[t] + 1);
      repeat (20) @(posedge clk);
      chk(fault_n, m > 8);
      chk(br, exp_br(m));
      chk(irq, m < 9 && m % 2 == 1);
      apb(1'b0, 8'h98, 32'h0);
      chk(rd[1:0], m < 8 ? 2 : m == 8 ? 3 : 0);
      demand <= 12'h000;
      apb(1'b1, 8'h94, 32'h100);
      apb(1'b1, 8'h9c, 32'h7);
      repeat (4) @(posedge clk);
      chk({fault_n, br, irq}, 5'h10);
    end
    // glitch of 10 clocks is shorter than the 10..11 tick filter
    apb(1'b1, 8'h90, 32'h0000_1800);
    demand <= 12'h064;
    repeat (10) @(posedge clk);
    demand <= 12'h000;
    repeat (30) @(posedge clk);
    chk(fault_n, 1);
    demand <= 12'h064;
    repeat (14) @(posedge clk);
    chk(fault_n, 1);
    repeat (20) @(posedge clk);
    chk(fault_n, 0);
    demand <= 12'h000;
    apb(1'b1, 8'h94, 32'h100);
    foreach (rq[i]) begin
      apb(1'b1, 8'h94, 32'h1);
      apb(1'b1, 8'h90, 32'(rq[i] << 15));
      demand <= 12'h064;
      repeat (20) @(posedge clk);
      apb(1'b0, 8'h98, 32'h0);
      chk({fault_n, rd[1:0]}, 3'h1);
      repeat (11800) @(posedge clk);
      apb(1'b0, 8'h98, 32'h0);
      chk(rd[1:0], 2'h1);
      repeat (300) @(posedge clk);
      apb(1'b0, 8'h98, 32'h0);
      chk({rd[7:4], rd[1:0]}, {4'h1, 2'h2});
      chk(br, exp_br(rq[i]));
      apb(1'b0, 8'h9c, 32'h0);
      chk(rd[2:0], 3'h7);
      demand <= 12'h000;
      apb(1'b1, 8'h94, 32'h101);
      apb(1'b1, 8'h9c, 32'h7);
      apb(1'b0, 8'h98, 32'h0);
      chk(rd[8:0], 9'h0);
    end
    print_verdict();
  end
endmodule
